/* design/iad_pkg.sv */
// Package for the integer datapath: register map, flag positions, opcodes, state.
// Assumes a single 50 MHz APB clock domain; nothing here carries timing.
package iad_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] IAD_OFS_OPA    = 8'h00;
  localparam logic [7:0] IAD_OFS_OPB    = 8'h04;
  localparam logic [7:0] IAD_OFS_CTRL   = 8'h08;
  localparam logic [7:0] IAD_OFS_RESLO  = 8'h0C;
  localparam logic [7:0] IAD_OFS_RESHI  = 8'h10;
  localparam logic [7:0] IAD_OFS_FLAGS  = 8'h14;
  localparam logic [7:0] IAD_OFS_STATUS = 8'h18;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int IAD_CTRL_CNT_LSB = 8;
  localparam int IAD_CTRL_TRUNC   = 16;
  localparam int IAD_CTRL_HALF    = 17;
  localparam int IAD_FLG_CARRY    = 0;
  localparam int IAD_FLG_PARITY   = 2;
  localparam int IAD_FLG_NIBBLE   = 4;
  localparam int IAD_FLG_ZERO     = 6;
  localparam int IAD_FLG_SIGN     = 7;
  localparam int IAD_FLG_OVER     = 11;
  localparam int IAD_STS_BUSY     = 0;
  localparam int IAD_STS_DIVERR   = 1;
  localparam logic [31:0] IAD_RST_WORD  = 32'h0000_0000;
  localparam logic [11:0] IAD_FLAG_MASK = 12'h8D5;
  localparam logic [7:0]  IAD_RADIX_TEN = 8'h0A;

  typedef enum logic [5:0] {
    IAD_ADD_ONE, IAD_SUB_ONE, IAD_COMPARE, IAD_SIGN_FLIP, IAD_UPRODUCT, IAD_SPRODUCT,
    IAD_UQUOTIENT, IAD_SQUOTIENT, IAD_PFIX_SUM, IAD_PFIX_DIFF, IAD_UFIX_SUM,
    IAD_UFIX_DIFF, IAD_UFIX_PROD, IAD_UFIX_QUOT, IAD_AND, IAD_OR, IAD_XOR, IAD_NOT,
    IAD_LSHIFT, IAD_LRSHIFT, IAD_ARSHIFT, IAD_DLSHIFT, IAD_DRSHIFT, IAD_ROTL,
    IAD_ROTR, IAD_CROTL, IAD_CROTR, IAD_PROBE, IAD_PROBE_SET, IAD_PROBE_CLR,
    IAD_PROBE_INV, IAD_LOW_SEARCH, IAD_HIGH_SEARCH
  } iad_op_type;

  typedef enum logic {
    IAD_IDLE = 1'b0,
    IAD_EXEC = 1'b1
  } iad_state_type;

  typedef struct packed {
    iad_op_type  op;
    logic [4:0]  cnt;
    logic        trunc;
    logic        half;
  } iad_ctrl_type;

  typedef struct packed {
    iad_state_type st;
    iad_ctrl_type  ctrl;
    logic [31:0]   opa;
    logic [31:0]   opb;
    logic [31:0]   res_lo;
    logic [31:0]   res_hi;
    logic [11:0]   flags;
    logic          div_err;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
  } iad_regs_type;

endpackage

/* design/iad_core.sv */
// Integer datapath with APB register access: arithmetic, decimal fixes, logic, shifts, bit ops.
// Assumes an APB master on pclk; writing CTRL launches one operation on OPA/OPB.
//
// Overview of operation
// - add-one and subtract-one change the operand by one and write it back.
// - compare forms first minus second and sets all six arithmetic flags.
// - compare changes no operand and no result, only flags.
// - sign-flip computes zero minus the operand.
// - unsigned product gives a result twice the source width.
// - signed product is double width, or truncated to source width on request.
// - quotient ops return quotient and remainder, unsigned or signed.
// - packed fix after sum makes two BCD digits, carry on decimal carry.
// - packed fix after difference makes two BCD digits, carry on borrow.
// - unpacked fix after sum keeps low digit, carry increments high byte.
// - unpacked fix after difference keeps digit, borrow decrements high byte.
// - unpacked fix after product splits low byte into two digits.
// - unpacked fix before quotient folds two digits into the low byte.
// - AND, OR, XOR on two operands and NOT on one.
// - left shift by 1 to 31 clears low bits, carry gets last out.
// - logical right shift clears high bits, carry gets last out.
// - arithmetic right shift fills with sign, carry gets last out.
// - double left shift fills from source, source kept, carry last out.
// - rotates circulate bits without loss by 0 to 31.
// - carry rotates treat carry as a bit above the top bit.
// - after any rotate carry holds the last bit rotated out.
// - bit probes copy selected bit to carry, then keep, set, clear or invert.
// - searches return index of first set bit from bottom or top.
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
module iad_core
  import iad_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [11:0] arith_flags(input logic [31:0] r, input logic cry, input logic nib,
                                              input logic ov);
    logic [11:0] f;
    f = '0;
    f[IAD_FLG_CARRY]  = cry;
    f[IAD_FLG_PARITY] = ~^r[7:0];
    f[IAD_FLG_NIBBLE] = nib;
    f[IAD_FLG_ZERO]   = (r == '0);
    f[IAD_FLG_SIGN]   = r[31];
    f[IAD_FLG_OVER]   = ov;
    return f;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= IAD_OFS_STATUS);
  endfunction

  iad_regs_type r, next_r;
  logic         access;
  logic         commit;

  assign access = psel && penable;
  assign commit = access && r.pready;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [32:0] t33;
    logic [64:0] t65;
    logic [65:0] t66;
    logic [63:0] prod;
    logic [31:0] a, b, res;
    logic [7:0]  alo, ahi;
    logic        cry, nib, ov, upd;
    next_r = r;
    t33    = '0;
    t65    = '0;
    t66    = '0;
    prod   = '0;
    a      = r.opa;
    b      = r.opb;
    res    = r.opa;
    alo    = r.opa[7:0];
    ahi    = r.opa[15:8];
    cry    = r.flags[IAD_FLG_CARRY];
    nib    = r.flags[IAD_FLG_NIBBLE];
    ov     = r.flags[IAD_FLG_OVER];
    upd    = 1'b1;

    // APB: one wait state so that prdata and pready come from flops
    next_r.pready  = access && !r.pready;
    next_r.pslverr = access && !r.pready && !is_mapped(paddr);
    if (access && !r.pready) begin
      unique case (paddr)
        IAD_OFS_OPA:    next_r.prdata = r.opa;
        IAD_OFS_OPB:    next_r.prdata = r.opb;
        IAD_OFS_CTRL:   next_r.prdata = {14'h0, r.ctrl.half, r.ctrl.trunc, 3'h0, r.ctrl.cnt, 2'h0, r.ctrl.op};
        IAD_OFS_RESLO:  next_r.prdata = r.res_lo;
        IAD_OFS_RESHI:  next_r.prdata = r.res_hi;
        IAD_OFS_FLAGS:  next_r.prdata = {20'h0, r.flags};
        IAD_OFS_STATUS: next_r.prdata = {30'h0, r.div_err, r.st == IAD_EXEC};
        default:        next_r.prdata = IAD_RST_WORD;
      endcase
    end

    unique case (r.st)
      IAD_IDLE: begin
        if (commit && pwrite) begin
          unique case (paddr)
            IAD_OFS_OPA:   next_r.opa = pwdata;
            IAD_OFS_OPB:   next_r.opb = pwdata;
            IAD_OFS_FLAGS: next_r.flags = pwdata[11:0] & IAD_FLAG_MASK;
            IAD_OFS_CTRL: begin
              next_r.ctrl.op    = iad_op_type'(pwdata[5:0]);
              next_r.ctrl.cnt   = pwdata[IAD_CTRL_CNT_LSB +: 5];
              next_r.ctrl.trunc = pwdata[IAD_CTRL_TRUNC];
              next_r.ctrl.half  = pwdata[IAD_CTRL_HALF];
              next_r.st         = IAD_EXEC;
            end
            default: begin
            end
          endcase
        end
      end
      IAD_EXEC: begin
        // Register writes during the execute cycle are dropped; software polls STATUS.busy
        next_r.st = IAD_IDLE;
        unique case (r.ctrl.op)
          IAD_ADD_ONE: begin
            res = a + 32'h1;
            ov  = (a == 32'h7FFF_FFFF);
          end
          IAD_SUB_ONE: begin
            res = a - 32'h1;
            ov  = (a == 32'h8000_0000);
          end
          IAD_COMPARE, IAD_SIGN_FLIP: begin
            if (r.ctrl.op == IAD_SIGN_FLIP) begin
              b = a;
              a = '0;
            end
            t33 = {1'b0, a} - {1'b0, b};
            res = t33[31:0];
            cry = t33[32];
            nib = (a[3:0] < b[3:0]);
            ov  = (a[31] != b[31]) && (res[31] != a[31]);
            upd = (r.ctrl.op == IAD_SIGN_FLIP);
          end
          IAD_UPRODUCT, IAD_SPRODUCT: begin
            if (r.ctrl.half) begin
              prod = (r.ctrl.op == IAD_SPRODUCT)
                   ? 64'($signed(a[15:0]) * $signed(b[15:0]))
                   : 64'(a[15:0] * b[15:0]);
            end else if (r.ctrl.op == IAD_SPRODUCT) begin
              prod = 64'($signed(a) * $signed(b));
            end else begin
              prod = 64'(a) * 64'(b);
            end
            cry = r.ctrl.half ? (prod[31:16] != {16{prod[15] & (r.ctrl.op == IAD_SPRODUCT)}})
                              : (prod[63:32] != {32{prod[31] & (r.ctrl.op == IAD_SPRODUCT)}});
            ov  = cry;
            if (r.ctrl.trunc && r.ctrl.op == IAD_SPRODUCT) begin
              res = r.ctrl.half ? {{16{prod[15]}}, prod[15:0]} : prod[31:0];
              next_r.res_hi = '0;
            end else begin
              res = prod[31:0];
              next_r.res_hi = r.ctrl.half ? '0 : prod[63:32];
            end
          end
          IAD_UQUOTIENT, IAD_SQUOTIENT: begin
            // Divide by zero leaves everything as it was and raises div_err
            if (b == '0) begin
              upd            = 1'b0;
              next_r.div_err = 1'b1;
            end else if (r.ctrl.op == IAD_SQUOTIENT) begin
              res           = 32'($signed(a) / $signed(b));
              next_r.res_hi = 32'($signed(a) % $signed(b));
            end else begin
              res           = a / b;
              next_r.res_hi = a % b;
            end
          end
          IAD_PFIX_SUM, IAD_PFIX_DIFF: begin
            if (alo[3:0] > 4'h9 || nib) begin
              alo = (r.ctrl.op == IAD_PFIX_SUM) ? alo + 8'h06 : alo - 8'h06;
              nib = 1'b1;
            end
            if (r.opa[7:0] > 8'h99 || cry) begin
              alo = (r.ctrl.op == IAD_PFIX_SUM) ? alo + 8'h60 : alo - 8'h60;
              cry = 1'b1;
            end else begin
              cry = 1'b0;
            end
            res = {a[31:8], alo};
          end
          IAD_UFIX_SUM, IAD_UFIX_DIFF: begin
            if (alo[3:0] > 4'h9 || nib) begin
              alo = (r.ctrl.op == IAD_UFIX_SUM) ? alo + 8'h06 : alo - 8'h06;
              ahi = (r.ctrl.op == IAD_UFIX_SUM) ? ahi + 8'h01 : ahi - 8'h01;
              nib = 1'b1;
              cry = 1'b1;
            end else begin
              nib = 1'b0;
              cry = 1'b0;
            end
            res = {a[31:16], ahi, 4'h0, alo[3:0]};
          end
          IAD_UFIX_PROD: begin
            res = {a[31:16], 8'(alo / IAD_RADIX_TEN), 8'(alo % IAD_RADIX_TEN)};
          end
          IAD_UFIX_QUOT: begin
            res = {a[31:16], 8'h00, 8'(alo + 8'(ahi * IAD_RADIX_TEN))};
          end
          IAD_AND: res = a & b;
          IAD_OR:  res = a | b;
          IAD_XOR: res = a ^ b;
          IAD_NOT: res = ~a;
          IAD_LSHIFT: begin
            t33 = {1'b0, a} << r.ctrl.cnt;
            res = t33[31:0];
            if (r.ctrl.cnt != '0) cry = t33[32];
          end
          IAD_LRSHIFT, IAD_ARSHIFT: begin
            t33 = (r.ctrl.op == IAD_ARSHIFT)
                ? 33'($signed({a, 1'b0}) >>> r.ctrl.cnt)
                : {a, 1'b0} >> r.ctrl.cnt;
            res = t33[32:1];
            if (r.ctrl.cnt != '0) cry = t33[0];
          end
          IAD_DLSHIFT: begin
            t65 = {1'b0, a, b} << r.ctrl.cnt;
            res = t65[63:32];
            if (r.ctrl.cnt != '0) cry = t65[64];
          end
          IAD_DRSHIFT: begin
            t65 = {b, a, 1'b0} >> r.ctrl.cnt;
            res = t65[32:1];
            if (r.ctrl.cnt != '0) cry = t65[0];
          end
          IAD_ROTL, IAD_ROTR: begin
            t66 = (r.ctrl.op == IAD_ROTL) ? {2'b00, a, a} >> (6'd32 - 6'(r.ctrl.cnt))
                                          : {2'b00, a, a} >> r.ctrl.cnt;
            res = t66[31:0];
            if (r.ctrl.cnt != '0) cry = (r.ctrl.op == IAD_ROTL) ? res[0] : res[31];
          end
          IAD_CROTL, IAD_CROTR: begin
            // Carry sits above bit 31, so the loop is 33 bits long
            t66 = (r.ctrl.op == IAD_CROTL) ? {cry, a, cry, a} >> (6'd33 - 6'(r.ctrl.cnt))
                                           : {cry, a, cry, a} >> r.ctrl.cnt;
            res = t66[31:0];
            cry = t66[32];
          end
          IAD_PROBE, IAD_PROBE_SET, IAD_PROBE_CLR, IAD_PROBE_INV: begin
            cry = a[b[4:0]];
            unique case (r.ctrl.op)
              IAD_PROBE_SET: res[b[4:0]] = 1'b1;
              IAD_PROBE_CLR: res[b[4:0]] = 1'b0;
              IAD_PROBE_INV: res[b[4:0]] = ~cry;
              default:       res = a;
            endcase
          end
          IAD_LOW_SEARCH, IAD_HIGH_SEARCH: begin
            // A zero source sets zero_flag and leaves the destination alone
            for (int i = 31; i >= 0; i--) begin
              if (r.ctrl.op == IAD_LOW_SEARCH && b[i]) res = 32'(i);
            end
            for (int i = 0; i < 32; i++) begin
              if (r.ctrl.op == IAD_HIGH_SEARCH && b[i]) res = 32'(i);
            end
            upd = 1'b0;
            next_r.flags[IAD_FLG_ZERO] = (b == '0);
            if (b != '0) begin
              next_r.opa    = res;
              next_r.res_lo = res;
            end
          end
          default: upd = 1'b0;
        endcase
        if (r.ctrl.op == IAD_COMPARE || upd) begin
          next_r.flags = arith_flags(res, cry, nib, ov);
          if (r.ctrl.op inside {IAD_PFIX_SUM, IAD_PFIX_DIFF, IAD_UFIX_SUM, IAD_UFIX_DIFF,
                                IAD_UFIX_PROD, IAD_UFIX_QUOT}) begin
            next_r.flags = arith_flags({24'h0, res[7:0]}, cry, nib, ov);
          end
        end
        if (upd) begin
          next_r.opa    = res;
          next_r.res_lo = res;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign prdata  = r.prdata;
  assign pready  = r.pready;
  assign pslverr = r.pslverr;

  // ****************************************
  // Checks
  // ****************************************
  logic ex;
  assign ex = (r.st == IAD_EXEC);

  chk_add_one_wb: assert property (@(posedge pclk) disable iff (!presetn)
    ex && r.ctrl.op == IAD_ADD_ONE |=> r.opa == $past(r.opa) + 32'h1) else $error("add-one wrong");
  chk_compare_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    ex && r.ctrl.op == IAD_COMPARE |=> $stable(r.opa) && $stable(r.opb) && $stable(r.res_lo))
    else $error("compare changed data");
  chk_compare_zero: assert property (@(posedge pclk) disable iff (!presetn)
    ex && r.ctrl.op == IAD_COMPARE |=> r.flags[IAD_FLG_ZERO] == ($past(r.opa) == $past(r.opb)))
    else $error("compare zero flag wrong");
  chk_sign_flip: assert property (@(posedge pclk) disable iff (!presetn)
    ex && r.ctrl.op == IAD_SIGN_FLIP |=> r.opa == 32'(32'h0 - $past(r.opa))) else $error("negate wrong");
  chk_lshift_carry: assert property (@(posedge pclk) disable iff (!presetn)
    ex && r.ctrl.op == IAD_LSHIFT && r.ctrl.cnt == 5'h01 |=> r.flags[IAD_FLG_CARRY] == $past(r.opa[31]))
    else $error("shift carry wrong");
  chk_rotl_carry: assert property (@(posedge pclk) disable iff (!presetn)
    ex && r.ctrl.op == IAD_ROTL && r.ctrl.cnt != '0 |=> r.flags[IAD_FLG_CARRY] == r.opa[0])
    else $error("rotate carry wrong");
  chk_probe_set: assert property (@(posedge pclk) disable iff (!presetn)
    ex && r.ctrl.op == IAD_PROBE_SET |=> r.opa[$past(r.opb[4:0])] && r.flags[IAD_FLG_CARRY] ==
    $past(r.opa[r.opb[4:0]])) else $error("probe-set wrong");
  chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    access && !pready |=> pready ##1 !pready) else $error("pready timing wrong");
  chk_exec_once: assert property (@(posedge pclk) disable iff (!presetn)
    ex |=> !ex) else $error("execute lasted too long");
  // Index must point at a set bit with no set bit below it
  chk_search_index: assert property (@(posedge pclk) disable iff (!presetn)
    ex && r.ctrl.op == IAD_LOW_SEARCH && r.opb != '0 |=> r.opb[r.opa[4:0]] && r.opa[31:5] == 27'h0
    && ((r.opb & ((32'h1 << r.opa[4:0]) - 32'h1)) == 32'h0)) else $error("search index wrong");

  cov_divide: cover property (@(posedge pclk) disable iff (!presetn) ex && r.ctrl.op == IAD_SQUOTIENT);
  cov_crotr: cover property (@(posedge pclk) disable iff (!presetn) ex && r.ctrl.op == IAD_CROTR);
  cov_bad_addr: cover property (@(posedge pclk) disable iff (!presetn) pslverr && pready);
  cov_half_prod: cover property (@(posedge pclk) disable iff (!presetn) ex && r.ctrl.half);

endmodule

/* tb/iad_host_model.sv */
// APB master standing in for the processor that programs the datapath's registers.
// Assumes pready comes from a flop of the slave; every wait is bounded.
`timescale 1ns/1ps
module iad_host_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  output logic             hung
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    hung = 1'b0;
  end

  // ****************************************
  // One transfer: setup, then access until pready
  // ****************************************
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) hung <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show the inverse so a stale value never passes
    pwrite <= ~w;
    paddr <= ~a;
    pwdata <= ~d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h00000000);
  endtask
endmodule

/* tb/iad_core_tb_top.sv */
// Self-checking bench for the integer datapath, driven over APB.
// Assumes the host model for bus cycles; expectations queue up per read.
`timescale 1ns/1ps
module iad_core_tb_top
  import iad_pkg::*;
;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} iad_note_type;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, hung;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, s, a, b;
  logic [4:0]  c;
  int          n_mismatch, cmp_count, ntest;
  iad_note_type q[$];
  iad_note_type nt;
  localparam logic [11:0] cy = 12'h001;

  iad_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  iad_host_model host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .hung(hung));

  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // ****************************************
  // Monitor: each completed read takes the oldest note
  // ****************************************
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
      nt = q.pop_front();
      cmp_count++;
      if (((prdata & nt.m) !== (nt.d & nt.m)) || (pslverr !== nt.e)) begin
        n_mismatch++;
        $display("BAD %0t got %h/%h exp %h/%h", $time, prdata, pslverr, nt.d, nt.e);
      end
    end
  end

  always @(posedge hung) begin
    n_mismatch++;
    close_out();
  end

  task automatic close_out();
    if (q.size() != 0) n_mismatch++;
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] d, input logic [31:0] m, input logic e);
    q.push_back('{d, m, e});
    host.rd(ad);
  endtask

  // Load operands and carry, launch, then read result and masked flags
  task automatic v(input iad_op_type op, input logic [4:0] n, input logic [31:0] x, y,
                   input logic [11:0] fi, input logic [7:0] ra, input logic [31:0] ev,
                   input logic [11:0] fx, fm);
    host.wr(IAD_OFS_OPA, x);
    host.wr(IAD_OFS_OPB, y);
    host.wr(IAD_OFS_FLAGS, {20'h00000, fi});
    host.wr(IAD_OFS_CTRL, 32'(op) | (32'(n) << IAD_CTRL_CNT_LSB));
    rd(ra, ev, 32'hFFFFFFFF, 1'b0);
    if (fm != 12'h000) rd(IAD_OFS_FLAGS, {20'h00000, fx}, {20'h00000, fm}, 1'b0);
    ntest++;
    $display("test %0d done", ntest);
  endtask

  // Product with the trunc or half bit set: both result words, carry and the control readback
  task automatic pv(input logic [31:0] ctl, x, y, lo, hi, input logic [11:0] fx);
    host.wr(IAD_OFS_OPA, x);
    host.wr(IAD_OFS_OPB, y);
    host.wr(IAD_OFS_CTRL, ctl);
    rd(IAD_OFS_RESLO, lo, 32'hFFFFFFFF, 1'b0);
    rd(IAD_OFS_RESHI, hi, 32'hFFFFFFFF, 1'b0);
    rd(IAD_OFS_FLAGS, {20'h00000, fx}, 32'h00000001, 1'b0);
    rd(IAD_OFS_CTRL, ctl, 32'hFFFFFFFF, 1'b0);
    ntest++;
    $display("test %0d done", ntest);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    presetn = 1'b0;
    s = 32'h00014238;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) rd(8'(4 * i), 32'h00000000, 32'hFFFFFFFF, 1'b0);
    rd(8'h1C, 32'h00000000, 32'hFFFFFFFF, 1'b1);
    rd(8'h02, 32'h00000000, 32'hFFFFFFFF, 1'b1);
    host.wr(IAD_OFS_RESLO, 32'hA5A5A5A5);
    rd(IAD_OFS_RESLO, 32'h00000000, 32'hFFFFFFFF, 1'b0);
    $display("register map test done");
    v(IAD_ADD_ONE, 0, 32'hFFFFFFFF, 0, 0, IAD_OFS_OPA, 32'h0, 0, 0);
    v(IAD_SUB_ONE, 0, 32'h0, 0, 0, IAD_OFS_OPA, 32'hFFFFFFFF, 0, 0);
    v(IAD_COMPARE, 0, 32'h3, 32'h5, 0, IAD_OFS_OPA, 32'h3, 12'h091, IAD_FLAG_MASK);
    rd(IAD_OFS_OPB, 32'h5, 32'hFFFFFFFF, 1'b0);
    v(IAD_COMPARE, 0, 32'h80000000, 32'h1, 0, IAD_OFS_OPA, 32'h80000000, 12'h814, IAD_FLAG_MASK);
    v(IAD_SIGN_FLIP, 0, 32'h5, 0, 0, IAD_OFS_OPA, 32'hFFFFFFFB, 0, 0);
    v(IAD_UPRODUCT, 0, 32'hFFFFFFFF, 32'h2, 0, IAD_OFS_RESLO, 32'hFFFFFFFE, 0, 0);
    rd(IAD_OFS_RESHI, 32'h1, 32'hFFFFFFFF, 1'b0);
    v(IAD_SPRODUCT, 0, 32'hFFFFFFFD, 32'h5, 0, IAD_OFS_RESLO, 32'hFFFFFFF1, 0, 0);
    rd(IAD_OFS_RESHI, 32'hFFFFFFFF, 32'hFFFFFFFF, 1'b0);
    pv(32'(IAD_SPRODUCT) | (32'h1 << IAD_CTRL_HALF), 32'h1234FFFD, 32'hABCD0005, 32'hFFFFFFF1, 32'h0, 12'h000);
    pv(32'(IAD_SPRODUCT) | (32'h1 << IAD_CTRL_TRUNC), 32'h00010000, 32'h00010000, 32'h0, 32'h0, cy);
    pv(32'(IAD_UPRODUCT) | (32'h1 << IAD_CTRL_HALF), 32'hABCDFFFF, 32'h1234FFFF, 32'hFFFE0001, 32'h0, cy);
    v(IAD_UQUOTIENT, 0, 32'h64, 32'h7, 0, IAD_OFS_RESLO, 32'hE, 0, 0);
    rd(IAD_OFS_RESHI, 32'h2, 32'hFFFFFFFF, 1'b0);
    v(IAD_SQUOTIENT, 0, 32'hFFFFFF9C, 32'h7, 0, IAD_OFS_RESLO, 32'hFFFFFFF2, 0, 0);
    rd(IAD_OFS_RESHI, 32'hFFFFFFFE, 32'hFFFFFFFF, 1'b0);
    v(IAD_UQUOTIENT, 0, 32'h9, 32'h0, 0, IAD_OFS_STATUS, 32'h2, 0, 0);
    v(IAD_PFIX_SUM, 0, 32'h9A, 0, 0, IAD_OFS_OPA, 32'h0, cy, cy);
    v(IAD_PFIX_SUM, 0, 32'h7D, 0, 0, IAD_OFS_OPA, 32'h83, 0, cy);
    v(IAD_PFIX_DIFF, 0, 32'hFF, 0, 0, IAD_OFS_OPA, 32'h99, cy, cy);
    v(IAD_UFIX_SUM, 0, 32'h20B, 0, 0, IAD_OFS_OPA, 32'h301, cy, cy);
    v(IAD_UFIX_DIFF, 0, 32'h50B, 0, 0, IAD_OFS_OPA, 32'h405, cy, cy);
    v(IAD_UFIX_PROD, 0, 32'h3F, 0, 0, IAD_OFS_OPA, 32'h603, 0, 0);
    v(IAD_UFIX_QUOT, 0, 32'h705, 0, 0, IAD_OFS_OPA, 32'h4B, 0, 0);
    v(IAD_AND, 0, 32'hF0F01234, 32'h0FF0FF00, 0, IAD_OFS_OPA, 32'h00F01200, 0, 0);
    v(IAD_OR, 0, 32'hF0F01234, 32'h0FF0FF00, 0, IAD_OFS_OPA, 32'hFFF0FF34, 0, 0);
    v(IAD_NOT, 0, 32'hF0F01234, 0, 0, IAD_OFS_OPA, 32'h0F0FEDCB, 0, 0);
    v(IAD_LSHIFT, 1, 32'h80000001, 0, 0, IAD_OFS_OPA, 32'h2, cy, cy);
    v(IAD_LRSHIFT, 2, 32'h80000003, 0, 0, IAD_OFS_OPA, 32'h20000000, cy, cy);
    v(IAD_ARSHIFT, 3, 32'h80000004, 0, 0, IAD_OFS_OPA, 32'hF0000000, cy, cy);
    v(IAD_DLSHIFT, 4, 32'h12345678, 32'h9ABCDEF1, 0, IAD_OFS_OPA, 32'h23456789, cy, cy);
    rd(IAD_OFS_OPB, 32'h9ABCDEF1, 32'hFFFFFFFF, 1'b0);
    v(IAD_DRSHIFT, 4, 32'h12345678, 32'h9ABCDEF1, 0, IAD_OFS_OPA, 32'h11234567, cy, cy);
    v(IAD_ROTL, 1, 32'h80000001, 0, 0, IAD_OFS_OPA, 32'h3, cy, cy);
    v(IAD_ROTR, 2, 32'h2, 0, 0, IAD_OFS_OPA, 32'h80000000, cy, cy);
    v(IAD_ROTL, 0, 32'h0, 0, cy, IAD_OFS_OPA, 32'h0, cy, cy);
    v(IAD_CROTL, 1, 32'h80000000, 0, cy, IAD_OFS_OPA, 32'h1, cy, cy);
    v(IAD_CROTR, 1, 32'h0, 0, cy, IAD_OFS_OPA, 32'h80000000, 0, cy);
    v(IAD_PROBE, 0, 32'h10, 32'h4, 0, IAD_OFS_OPA, 32'h10, cy, cy);
    v(IAD_PROBE_SET, 0, 32'h10, 32'h5, cy, IAD_OFS_OPA, 32'h30, 0, cy);
    v(IAD_PROBE_CLR, 0, 32'h10, 32'h4, 0, IAD_OFS_OPA, 32'h0, cy, cy);
    v(IAD_PROBE_INV, 0, 32'h10, 32'h0, cy, IAD_OFS_OPA, 32'h11, 0, cy);
    v(IAD_LOW_SEARCH, 0, 0, 32'h00100100, 0, IAD_OFS_OPA, 32'h8, 0, 0);
    v(IAD_HIGH_SEARCH, 0, 0, 32'h00100100, 0, IAD_OFS_OPA, 32'h14, 0, 0);
    // Random operands and shift counts from the fixed seed
    for (int i = 0; i < 4; i++) begin
      s = lfsr(s);
      a = s;
      s = lfsr(s);
      b = s;
      c = (s[4:0] == 5'h00) ? 5'h01 : s[4:0];
      v(IAD_XOR, 0, a, b, 0, IAD_OFS_OPA, a ^ b, 0, 0);
      v(IAD_ADD_ONE, 0, a, 0, 0, IAD_OFS_OPA, a + 32'h1, 0, 0);
      v(IAD_LSHIFT, c, a, 0, 0, IAD_OFS_OPA, a << c, {11'h000, a[6'd32 - c]}, cy);
    end
    // Second reset in mid-run clears the sticky error
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(IAD_OFS_STATUS, 32'h0, 32'hFFFFFFFF, 1'b0);
    rd(IAD_OFS_OPA, 32'h0, 32'hFFFFFFFF, 1'b0);
    $display("second reset test done");
    repeat (2) @(posedge pclk);
    close_out();
  end
endmodule
